/* hw/dwt_pkg.sv */
// constants and types shared by the data word decoder and trim logic
package dwt_pkg;
	// ========================================================================
	// sizes
	localparam int NUM_CH  = 40;          // converter channels
	localparam int CH_W    = 6;           // channel address width
	localparam int DATA_W  = 12;          // data word width
	localparam int RES_N   = 12;          // converter resolution in bits
	localparam int PROD_W  = 25;          // width of gain times input product

	// ========================================================================
	// reset values
	localparam logic [11:0] INPUT_RESET  = 12'h000; // input code after reset
	localparam logic [11:0] GAIN_RESET   = 12'hFFE; // unity gain coefficient
	localparam logic [11:0] OFFSET_RESET = 12'h800; // zero offset coefficient
	localparam logic [11:0] CLRCODE_RESET = 12'h000; // clear code after reset
	localparam logic [11:0] CTRL_RESET   = 12'h800; // amplifier high-z in power-down
	localparam logic [5:0]  MON_RESET    = 6'h3F;   // monitor output three-stated

	// ========================================================================
	// arithmetic constants
	localparam logic [11:0] GAIN_MASK  = 12'hFFE;   // gain lsb always zero
	localparam logic [12:0] GAIN_BIAS  = 13'h0002;  // gain plus two
	localparam logic [14:0] HALF_RANGE = 15'h0800;  // two to the n minus one
	localparam logic [11:0] CODE_MAX   = 12'hFFF;   // full scale string code
	localparam logic [11:0] CODE_MIN   = 12'h000;   // zero scale string code
	localparam logic [5:0]  LAST_CH    = 6'h27;     // highest channel index

	// ========================================================================
	// register select codes
	localparam logic [1:0] SEL_INPUT  = 2'h3;
	localparam logic [1:0] SEL_OFFSET = 2'h2;
	localparam logic [1:0] SEL_GAIN   = 2'h1;
	localparam logic [1:0] SEL_SPECIAL = 2'h0;

	// ========================================================================
	// special command codes
	localparam logic [5:0] CMD_NOP      = 6'h00;
	localparam logic [5:0] CMD_CLR_CODE = 6'h01;
	localparam logic [5:0] CMD_SOFT_CLR = 6'h02;
	localparam logic [5:0] CMD_PWR_DOWN = 6'h08;
	localparam logic [5:0] CMD_PWR_UP   = 6'h09;
	localparam logic [5:0] CMD_MONITOR  = 6'h0A;
	localparam logic [5:0] CMD_CTRL     = 6'h0C;
	localparam logic [5:0] CMD_SOFT_RST = 6'h0F;

	// ========================================================================
	// control word bit positions
	localparam int CR_REF_MAG = 10;       // reference magnitude bit
	localparam int CR_REF_SRC = 8;        // reference source bit
	localparam int MON_MSB    = 11;       // monitor channel field
	localparam int MON_LSB    = 6;

	// ========================================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FILL,
		ST_CLEAR,
		ST_LOAD_RD,
		ST_LOAD_WR
	} dwt_state_t;
endpackage

/* hw/dwt_word_ram.sv */
// small word memory with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module dwt_word_ram
#(
	parameter int WIDTH = 12,
	parameter int DEPTH = 40,
	parameter int AW    = 6
)
(
	// clock, reset, enable
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// write port
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	// read port
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);
	// ========================================================================
	// storage
	logic [WIDTH-1:0] mem [DEPTH];        // word array

	// write, guarded against addresses past the last word
	always_ff @(posedge clk)
	begin
		if (ce && we && (int'(waddr) < DEPTH))
			mem[waddr] <= wdata;
	end

	// registered read, zero for addresses past the last word
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= '0;
		else if (ce)
			rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : '0;
	end
endmodule
`default_nettype wire

/* hw/dwt_decode_trim.sv */
// data word decoder, special commands and gain/offset trim for 40 channels
`timescale 1ns/1ps
`default_nettype none
module dwt_decode_trim
#(
	parameter logic REF_MAG_DEFAULT = 1'b1 // reference magnitude after soft reset
)
(
	// clock, reset, enable
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// host data word
	input  wire logic        word_valid,
	input  wire logic        word_read,
	input  wire logic        register_select_high,
	input  wire logic        register_select_low,
	input  wire logic [5:0]  command_address_bits,
	input  wire logic [11:0] data_word_bits,
	// hardware strobes
	input  wire logic        load_outputs_strobe,
	input  wire logic        clear_preset,
	// string side
	input  wire logic [5:0]  string_sel,
	output logic      [11:0] trimmed_string_code,
	output logic             outputs_commit,
	// status and readback
	output logic             busy_n,
	output logic      [11:0] read_data,
	output logic             read_valid,
	// configuration
	output logic      [11:0] control_word,
	output logic             ref_internal_en,
	output logic             ref_level_high,
	output logic             power_down,
	output logic      [5:0]  monitor_chan
);
	// ========================================================================
	// state
	dwt_pkg::dwt_state_t state_reg;       // sequencer state
	dwt_pkg::dwt_state_t state_next;
	logic [5:0]  idx_reg;                 // sweep channel index
	logic [5:0]  idx_next;
	logic [11:0] ctrl_reg;                // control word
	logic [11:0] clr_code_reg;            // clear preset code
	logic [5:0]  mon_reg;                 // monitored channel
	logic        pd_reg;                  // software power-down
	logic        load_pend_reg;           // load strobe waiting
	logic        clr_pend_reg;            // clear request waiting
	logic        busy_n_reg;              // busy indication, low active
	logic [11:0] rd_data_reg;             // readback word
	logic        rd_valid_reg;            // readback presented
	logic        commit_reg;              // sweep finished pulse

	// ========================================================================
	// word decode
	wire [1:0] sel       = {register_select_high, register_select_low};
	wire       idle      = (state_reg == dwt_pkg::ST_IDLE);
	wire       acc       = ce && word_valid && idle;
	wire       ch_ok     = (command_address_bits <= dwt_pkg::LAST_CH);
	wire       wr_ok     = acc && !word_read && !pd_reg;
	wire       is_sfr    = acc && (sel == dwt_pkg::SEL_SPECIAL);
	wire [5:0] cmd       = command_address_bits;
	// routing by select bits, writes blocked during power-down
	wire we_input  = wr_ok && ch_ok && (sel == dwt_pkg::SEL_INPUT);
	wire we_offset = wr_ok && ch_ok && (sel == dwt_pkg::SEL_OFFSET);
	wire we_gain   = wr_ok && ch_ok && (sel == dwt_pkg::SEL_GAIN);
	// special commands
	wire c_nop     = is_sfr && (cmd == dwt_pkg::CMD_NOP);
	wire c_clrcode = is_sfr && !word_read && !pd_reg && (cmd == dwt_pkg::CMD_CLR_CODE);
	wire c_softclr = is_sfr && !word_read && !pd_reg && (cmd == dwt_pkg::CMD_SOFT_CLR);
	wire c_pdown   = is_sfr && !word_read && (cmd == dwt_pkg::CMD_PWR_DOWN);
	wire c_pup     = is_sfr && !word_read && (cmd == dwt_pkg::CMD_PWR_UP);
	wire c_ctrl_wr = is_sfr && !word_read && !pd_reg && (cmd == dwt_pkg::CMD_CTRL);
	wire c_ctrl_rd = is_sfr && word_read && (cmd == dwt_pkg::CMD_CTRL);
	wire c_monitor = is_sfr && !word_read && !pd_reg && (cmd == dwt_pkg::CMD_MONITOR);
	wire c_softrst = is_sfr && !word_read && (cmd == dwt_pkg::CMD_SOFT_RST);
	// any other code falls through every decode above and changes nothing

	// ========================================================================
	// coefficient and buffer memories
	wire        fill    = (state_reg == dwt_pkg::ST_FILL);
	wire        load_wr = (state_reg == dwt_pkg::ST_LOAD_WR);
	wire        clr_wr  = (state_reg == dwt_pkg::ST_CLEAR);
	wire [5:0]  waddr   = idle ? command_address_bits : idx_reg;
	wire [11:0] in_rd;                    // first stage input code
	wire [11:0] gain_rd;                  // gain coefficient
	wire [11:0] offs_rd;                  // offset coefficient
	wire [11:0] gain_wd = fill ? dwt_pkg::GAIN_RESET
	                           : (data_word_bits & dwt_pkg::GAIN_MASK);
	wire [11:0] offs_wd = fill ? dwt_pkg::OFFSET_RESET : data_word_bits;
	wire [11:0] in_wd   = fill ? dwt_pkg::INPUT_RESET : data_word_bits;
	wire [11:0] x2_code;                  // trimmed code of swept channel
	wire [11:0] dac_wd  = load_wr ? x2_code : (clr_wr ? clr_code_reg : dwt_pkg::INPUT_RESET);
	wire        dac_we  = fill || clr_wr || load_wr;

	// per channel first stage, one word per channel
	dwt_word_ram u_input (
		.clk   (core_clk),
		.rst   (rst),
		.ce    (ce),
		.we    (we_input || fill),
		.waddr (waddr),
		.wdata (in_wd),
		.raddr (idx_reg),
		.rdata (in_rd)
	);

	// per channel gain coefficient
	dwt_word_ram u_gain (
		.clk   (core_clk),
		.rst   (rst),
		.ce    (ce),
		.we    (we_gain || fill),
		.waddr (waddr),
		.wdata (gain_wd),
		.raddr (idx_reg),
		.rdata (gain_rd)
	);

	// per channel offset coefficient
	dwt_word_ram u_offset (
		.clk   (core_clk),
		.rst   (rst),
		.ce    (ce),
		.we    (we_offset || fill),
		.waddr (waddr),
		.wdata (offs_wd),
		.raddr (idx_reg),
		.rdata (offs_rd)
	);

	// second stage, the codes that drive the strings
	dwt_word_ram u_dac (
		.clk   (core_clk),
		.rst   (rst),
		.ce    (ce),
		.we    (dac_we),
		.waddr (idx_reg),
		.wdata (dac_wd),
		.raddr (string_sel),
		.rdata (trimmed_string_code)
	);

	// ========================================================================
	// trim arithmetic: x2 = (m+2) * x1 / 2^n + c - 2^(n-1)
	wire [12:0] gain_p2 = {1'b0, gain_rd} + dwt_pkg::GAIN_BIAS;
	wire [24:0] prod    = {12'h000, gain_p2} * {13'h0000, in_rd};
	wire [12:0] scaled  = prod[24:12];    // divide by 2^n
	wire [14:0] sum     = {2'b00, scaled} + {3'b000, offs_rd} - dwt_pkg::HALF_RANGE;
	// negative sums pin to zero, sums past twelve bits pin to full scale
	assign x2_code = sum[14] ? dwt_pkg::CODE_MIN
	               : (|sum[13:12]) ? dwt_pkg::CODE_MAX : sum[11:0];

	// ========================================================================
	// sequencer next state: reset fill beats clear, clear beats load
	wire at_last = (idx_reg == dwt_pkg::LAST_CH);

	always_comb
	begin
		state_next = state_reg;
		idx_next   = idx_reg;
		unique case (state_reg)
			dwt_pkg::ST_IDLE:
			begin
				idx_next = '0;
				if (c_softrst)
					state_next = dwt_pkg::ST_FILL;
				else if (clr_pend_reg)
					state_next = dwt_pkg::ST_CLEAR;
				else if (load_pend_reg)
					state_next = dwt_pkg::ST_LOAD_RD;
			end
			dwt_pkg::ST_FILL, dwt_pkg::ST_CLEAR:
			begin
				// one channel per cycle
				idx_next = at_last ? '0 : idx_reg + 6'h01;
				if (at_last)
					state_next = dwt_pkg::ST_IDLE;
			end
			dwt_pkg::ST_LOAD_RD:
				// memories present this channel next cycle
				state_next = dwt_pkg::ST_LOAD_WR;
			dwt_pkg::ST_LOAD_WR:
			begin
				idx_next   = at_last ? '0 : idx_reg + 6'h01;
				state_next = at_last ? dwt_pkg::ST_IDLE : dwt_pkg::ST_LOAD_RD;
			end
		endcase
	end

	// sequencer registers, reset starts a default fill
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= dwt_pkg::ST_FILL;
			idx_reg   <= '0;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
		end
	end

	// ========================================================================
	// pending strobes: a new strobe wins over the clear that starts a sweep
	wire load_start = idle && !c_softrst && !clr_pend_reg && load_pend_reg;
	wire clr_start  = idle && !c_softrst && clr_pend_reg;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			load_pend_reg <= 1'b0;
			clr_pend_reg  <= 1'b0;
		end
		else if (ce)
		begin
			load_pend_reg <= load_outputs_strobe || (load_pend_reg && !load_start && !c_softrst);
			clr_pend_reg  <= clear_preset || c_softclr
			                 || (clr_pend_reg && !clr_start && !c_softrst);
		end
	end

	// ========================================================================
	// configuration registers
	wire [11:0] ctrl_rst_val = dwt_pkg::CTRL_RESET
	                         | (12'(REF_MAG_DEFAULT) << dwt_pkg::CR_REF_MAG);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg     <= dwt_pkg::CTRL_RESET;  // reference source external
			clr_code_reg <= dwt_pkg::CLRCODE_RESET;
			mon_reg      <= dwt_pkg::MON_RESET;
			pd_reg       <= 1'b0;
		end
		else if (ce)
		begin
			// soft reset restores the configuration defaults, ctrl_reg taking REF_MAG_DEFAULT in bit 10
			if (c_softrst)
			begin
				ctrl_reg     <= ctrl_rst_val;
				clr_code_reg <= dwt_pkg::CLRCODE_RESET;
				mon_reg      <= dwt_pkg::MON_RESET;
				pd_reg       <= 1'b0;
			end
			else
			begin
				if (c_ctrl_wr)
					ctrl_reg <= data_word_bits;
				if (c_clrcode)
					clr_code_reg <= data_word_bits;
				if (c_monitor)
					mon_reg <= data_word_bits[dwt_pkg::MON_MSB:dwt_pkg::MON_LSB];
				if (c_pdown)
					pd_reg <= 1'b1;
				else if (c_pup)
					pd_reg <= 1'b0;
			end
		end
	end

	// ========================================================================
	// busy, readback and commit
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			busy_n_reg   <= 1'b1;
			rd_data_reg  <= '0;
			rd_valid_reg <= 1'b0;
			commit_reg   <= 1'b0;
		end
		else if (ce)
		begin
			// low while sweeping and for one cycle on a nop
			busy_n_reg   <= !(c_nop || c_softrst || c_softclr || clr_start || load_start
			                  || (!idle && !(at_last && state_next == dwt_pkg::ST_IDLE)));
			if (c_ctrl_rd)
				rd_data_reg <= ctrl_reg;
			// a nop presents the held word again for shifting out
			rd_valid_reg <= c_ctrl_rd || c_nop;
			// all strings take their new codes together at the end
			commit_reg   <= (load_wr || clr_wr || fill) && at_last;
		end
	end

	// ========================================================================
	// outputs
	assign busy_n          = busy_n_reg;
	assign read_data       = rd_data_reg;
	assign read_valid      = rd_valid_reg;
	assign outputs_commit  = commit_reg;
	assign control_word    = ctrl_reg;
	assign ref_internal_en = ctrl_reg[dwt_pkg::CR_REF_SRC]; // one selects internal
	assign ref_level_high  = ctrl_reg[dwt_pkg::CR_REF_MAG]; // one selects 2.5 V
	assign power_down      = pd_reg;
	assign monitor_chan    = mon_reg;
endmodule
`default_nettype wire

/* dv/dwt_host_model.sv */
// host model that sends data words and strobes to the decoder
`timescale 1ns/1ps
`default_nettype none
module dwt_host_model
(
	// clock and status
	input  wire logic        core_clk,
	input  wire logic        busy_n,
	// data word
	output var logic         word_valid,
	output var logic         word_read,
	output var logic         register_select_high,
	output var logic         register_select_low,
	output var logic  [5:0]  command_address_bits,
	output var logic  [11:0] data_word_bits,
	// hardware strobes
	output var logic         load_outputs_strobe,
	output var logic         clear_preset
);
	// ========================================================================
	// idle levels
	initial
	begin
		{word_valid, word_read, register_select_high, register_select_low} = 4'h0;
		{command_address_bits, data_word_bits} = 18'h0;
		{load_outputs_strobe, clear_preset} = 2'h0;
	end

	// wait until a started sweep has ended, bounded
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (3) @(posedge core_clk);
		#1;
		while (busy_n !== 1'b1 && n < 3000)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask

	// one word; a random gap makes the host slow at times
	task automatic send(input logic rd, input logic [1:0] sel, input logic [5:0] a,
		input logic [11:0] d);
		int n;
		n = $urandom_range(2);
		repeat (n + 1) @(posedge core_clk);
		#1;
		while (busy_n !== 1'b1)
		begin
			@(posedge core_clk);
			#1;
		end
		// selects 00 turn the address into a command code
		{word_read, register_select_high, register_select_low} = {rd, sel};
		command_address_bits = a;
		data_word_bits = d;
		word_valid = 1'b1;
		@(posedge core_clk);
		#1;
		// released lines no longer show the last value
		word_valid = 1'b0;
		command_address_bits = ~a;
		data_word_bits = ~d;
	endtask

	// one-cycle strobe: 0 load, 1 clear
	task automatic pulse(input logic which);
		@(posedge core_clk);
		#1;
		{clear_preset, load_outputs_strobe} = which ? 2'h2 : 2'h1;
		@(posedge core_clk);
		#1;
		{clear_preset, load_outputs_strobe} = 2'h0;
	endtask
endmodule
`default_nettype wire

/* dv/dwt_decode_trim_asserts.sv */
// concurrent checks on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module dwt_decode_trim_asserts
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// host side
	input  wire logic        word_valid,
	input  wire logic        word_read,
	input  wire logic        register_select_high,
	input  wire logic        register_select_low,
	input  wire logic [5:0]  command_address_bits,
	input  wire logic [11:0] data_word_bits,
	input  wire logic        load_outputs_strobe,
	// outputs
	input  wire logic        busy_n,
	input  wire logic [11:0] read_data,
	input  wire logic        read_valid,
	input  wire logic        outputs_commit,
	input  wire logic [11:0] control_word,
	input  wire logic        ref_internal_en,
	input  wire logic        ref_level_high,
	input  wire logic        power_down,
	input  wire logic [5:0]  monitor_chan
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// ========================================================================
	// command word taken while idle
	sequence s_sfr(logic [5:0] code);
		ce && word_valid && busy_n && !register_select_high && !register_select_low
			&& command_address_bits == code;
	endsequence
	// load request seen while idle
	sequence s_load_req;
		ce && busy_n && load_outputs_strobe && !power_down && !word_valid;
	endsequence
	a_nop_busy_low: assert property (s_sfr(6'h00) |=> !busy_n)
		else $error("nop left busy high");
	a_ctrl_write: assert property (s_sfr(6'h0C) ##0 !word_read && !power_down
		|=> control_word == $past(data_word_bits)) else $error("control write lost");
	a_ctrl_read: assert property (s_sfr(6'h0C) ##0 word_read
		|=> read_valid && read_data == control_word) else $error("control read wrong");
	a_ref_follow: assert property (ref_internal_en == control_word[8]
		&& ref_level_high == control_word[10]) else $error("reference bits wrong");
	a_monitor_sel: assert property (s_sfr(6'h0A) ##0 !word_read && !power_down
		|=> monitor_chan == $past(data_word_bits[11:6])) else $error("monitor wrong");
	a_pwr_down: assert property (s_sfr(6'h08) ##0 !word_read |=> power_down)
		else $error("power down missed");
	a_pwr_up: assert property (s_sfr(6'h09) ##0 !word_read |=> !power_down)
		else $error("power up missed");
	a_unknown_cmd: assert property (s_sfr(6'h3E) |=> $stable(control_word)
		&& $stable(power_down) && $stable(monitor_chan)) else $error("unknown code acted");
	a_commit_end: assert property (outputs_commit |-> $rose(busy_n))
		else $error("commit outside sweep end");
	a_load_start: assert property (s_load_req |-> ##[1:3] !busy_n)
		else $error("load sweep not started");
endmodule
bind dwt_decode_trim dwt_decode_trim_asserts u_dwt_decode_trim_asserts
(
	.core_clk, .rst, .ce, .word_valid, .word_read, .register_select_high,
	.register_select_low, .command_address_bits, .data_word_bits, .load_outputs_strobe,
	.busy_n, .read_data, .read_valid, .outputs_commit, .control_word,
	.ref_internal_en, .ref_level_high, .power_down, .monitor_chan
);
`default_nettype wire

/* dv/dwt_decode_trim_tb_top.sv */
// self-checking bench for the data word decoder and trim
`timescale 1ns/1ps
`default_nettype none
module dwt_decode_trim_tb_top;
	logic        core_clk, rst, ce, word_valid, word_read, sel_hi, sel_lo;
	logic        load_strobe, clr_pin, commit, busy_n, read_valid;
	logic        ref_int, ref_hi, power_down;
	logic [5:0]  addr, string_sel, monitor_chan;
	logic [11:0] data, str_code, read_data, control_word;
	logic [11:0] exp_q[$];      // expected readback words
	logic [11:0] str_exp[40];   // expected second stage codes
	int          n_errors, total_checks;
	int          n_commit;    // sweep end pulses seen

	dwt_decode_trim u_dwt_decode_trim (.core_clk(core_clk), .rst(rst), .ce(ce),
		.word_valid(word_valid), .word_read(word_read), .register_select_high(sel_hi),
		.register_select_low(sel_lo), .command_address_bits(addr), .data_word_bits(data),
		.load_outputs_strobe(load_strobe), .clear_preset(clr_pin), .string_sel(string_sel),
		.trimmed_string_code(str_code), .outputs_commit(commit), .busy_n(busy_n),
		.read_data(read_data), .read_valid(read_valid), .control_word(control_word),
		.ref_internal_en(ref_int), .ref_level_high(ref_hi), .power_down(power_down),
		.monitor_chan(monitor_chan));
	dwt_host_model u_dwt_host_model (.core_clk(core_clk), .busy_n(busy_n),
		.word_valid(word_valid), .word_read(word_read), .register_select_high(sel_hi),
		.register_select_low(sel_lo), .command_address_bits(addr), .data_word_bits(data),
		.load_outputs_strobe(load_strobe), .clear_preset(clr_pin));

	// ========================================================================
	// compare, report, end
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// reference trim arithmetic with clamping
	function automatic logic [11:0] trim(logic [11:0] g, logic [11:0] x, logic [11:0] c);
		int t;
		t = (((int'(g) & 'hFFE) + 2) * int'(x)) >> 12;
		t = t + int'(c) - 2048;
		t = (t < 0) ? 0 : ((t > 4095) ? 4095 : t);
		return t[11:0];
	endfunction
	// second stage code of one channel
	task automatic check_str(input logic [5:0] ch, input logic [11:0] exp);
		string_sel = ch;
		@(posedge core_clk);
		@(posedge core_clk);
		#1 check(str_code, exp);
	endtask

	// readback watcher takes the oldest note per result, and counts sweep ends
	always @(negedge core_clk)
	begin
		if (commit === 1'b1)
			n_commit++;
		if (read_valid === 1'b1)
		begin
			// a readback with no note pending is always a mismatch
			if (exp_q.size() == 0)
				check({11'h0, read_valid}, 12'h000);
			else
				check(read_data, exp_q.pop_front());
		end
	end

	// clock and watchdog
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial
	begin
		#200000;
		n_errors++;
		stop_test();
	end

	// ========================================================================
	// main sequence
	initial
	begin : main
		logic [11:0] g, x, c, d;
		logic [5:0]  ch;
		{rst, ce, string_sel, n_errors, total_checks} = {2'h3, 6'h00, 64'h0};
		foreach (str_exp[i]) str_exp[i] = 12'h000;
		void'($urandom(32'h92150137));
		repeat (2) @(posedge core_clk);
		#1 rst = 1'b0;
		u_dwt_host_model.wait_idle();
		check(control_word, 12'h800);
		check({10'h0, ref_hi, ref_int}, 12'h000);
		check({6'h0, monitor_chan}, 12'h03F);
		$display("reset test done");
		// channel 39 keeps reset gain and offset; random channels get trims, the first two fixed extremes
		for (int i = 0; i < 6; i++)
		begin
			{g, x, c} = {12'hFFE, 12'($urandom), 12'h800};
			ch = 6'h27;
			if (i > 0)
			begin
				{g, x, c} = {12'($urandom), 12'($urandom), 12'($urandom)};
				if (i == 1) {g, x, c} = 36'hFFF_FFF_FFF;
				if (i == 2) {g, x, c} = 36'hFFF_000_000;
				ch = 6'($urandom_range(38));
				u_dwt_host_model.send(1'b0, dwt_pkg::SEL_GAIN, ch, g);
				u_dwt_host_model.send(1'b0, dwt_pkg::SEL_OFFSET, ch, c);
			end
			u_dwt_host_model.send(1'b0, dwt_pkg::SEL_INPUT, ch, x);
			check_str(ch, str_exp[ch]);
			u_dwt_host_model.pulse(1'b0);
			u_dwt_host_model.wait_idle();
			str_exp[ch] = trim(g, x, c);
			check_str(ch, str_exp[ch]);
		end
		$display("trim test done");
		d = 12'($urandom) | 12'h500;
		u_dwt_host_model.send(1'b0, 2'h0, dwt_pkg::CMD_CTRL, d);
		check(control_word, d);
		check({10'h0, ref_hi, ref_int}, 12'h003);
		exp_q.push_back(d);
		u_dwt_host_model.send(1'b1, 2'h0, dwt_pkg::CMD_CTRL, ~d);
		exp_q.push_back(d);
		u_dwt_host_model.send(1'b1, 2'h0, dwt_pkg::CMD_NOP, 12'($urandom));
		check({11'h0, busy_n}, 12'h000);
		u_dwt_host_model.send(1'b0, 2'h0, 6'h3E, ~d);
		check(control_word, d);
		check({6'h0, monitor_chan}, 12'h03F);
		u_dwt_host_model.send(1'b0, 2'h0, dwt_pkg::CMD_MONITOR, {ch, 6'h15});
		check({6'h0, monitor_chan}, {6'h0, ch});
		// a word offered while the clock enable is low is not taken
		ce = 1'b0;
		u_dwt_host_model.send(1'b0, 2'h0, dwt_pkg::CMD_CTRL, ~d);
		ce = 1'b1;
		check(control_word, d);
		$display("command test done");
		// clear by command then by pin, then load restores inputs
		d = 12'($urandom);
		u_dwt_host_model.send(1'b0, 2'h0, dwt_pkg::CMD_CLR_CODE, d);
		u_dwt_host_model.send(1'b0, 2'h0, dwt_pkg::CMD_SOFT_CLR, 12'h000);
		u_dwt_host_model.wait_idle();
		check_str(ch, d);
		u_dwt_host_model.send(1'b0, 2'h0, dwt_pkg::CMD_CLR_CODE, ~d);
		u_dwt_host_model.pulse(1'b1);
		u_dwt_host_model.wait_idle();
		check_str(ch, ~d);
		// writes ignored while powered down
		u_dwt_host_model.send(1'b0, 2'h0, dwt_pkg::CMD_PWR_DOWN, 12'h000);
		check({11'h0, power_down}, 12'h001);
		u_dwt_host_model.send(1'b0, dwt_pkg::SEL_INPUT, ch, ~x);
		u_dwt_host_model.send(1'b0, 2'h0, dwt_pkg::CMD_PWR_UP, 12'h000);
		check({11'h0, power_down}, 12'h000);
		u_dwt_host_model.pulse(1'b0);
		u_dwt_host_model.wait_idle();
		check_str(ch, str_exp[ch]);
		$display("clear and power test done");
		u_dwt_host_model.send(1'b0, 2'h0, dwt_pkg::CMD_SOFT_RST, 12'h000);
		u_dwt_host_model.wait_idle();
		check({11'h0, ref_int}, 12'h000);
		check({6'h0, monitor_chan}, 12'h03F);
		check_str(ch, 12'h000);
		check(12'(exp_q.size()), 12'h000);
		// two fills, six loads, two clears and one more load each end in one pulse
		check(12'(n_commit), 12'h00B);
		$display("soft reset test done");
		stop_test();
	end
endmodule
`default_nettype wire
